// ===== ssm_regs.svh
// register map, field positions, reset values and timing counts of the
// encoderless safe speed monitor; assumes a 32-bit apb register bus
`ifndef SSM_REGS_SVH
`define SSM_REGS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define SSM_CTRL_OFS        12'h000
`define SSM_LIMIT_OFS       12'h004
`define SSM_HYST_OFS        12'h008
`define SSM_FILTER_OFS      12'h00C
`define SSM_STATUS_OFS      12'h010

// ****************************************************************
// control fields and reset values
// ****************************************************************
`define SSM_CTRL_BEHAV_BIT  0
`define SSM_CTRL_HYSTF_BIT  1
`define SSM_CTRL_FSPEC_LSB  4
`define SSM_CTRL_FSPEC_MSB  5
`define SSM_BEHAV_RST       1'b1
`define SSM_HYSTF_RST       1'b0
`define SSM_FSPEC_RST       2'h0
`define SSM_FSPEC_MODE_A    2'h1
`define SSM_FSPEC_MODE_B    2'h3
`define SSM_SPEED_RST       16'h0000

// ****************************************************************
// timing
// ****************************************************************
`define SSM_CLK_PERIOD_NS   10
`define SSM_WINDOW_MS       5000
`endif

// ===== ssm_pkg.sv
// types shared by the speed monitor and its helpers
// assumes ssm_regs.svh for all numeric constants
package ssm_pkg;

  // ****************************************************************
  // monitor states
  // ****************************************************************
  typedef enum logic [2:0] {
    st_idle,       // monitoring off
    st_monitor,    // pulses enabled, speed compared
    st_supp_zero,  // suppressed, feedback forced low
    st_decay,      // suppressed, waiting for zero speed
    st_sto_hold,   // internal torque off, wait for select
    st_sto_sel,    // torque off selected, wait for deselect
    st_window      // restart window running
  } monitor_state_t;

  // drive-side inputs, all synchronous to pclk
  typedef struct packed {
    logic signed [15:0] speed_actual;       // estimated speed, signed
    logic               pulses_suppressed;  // power stage pulses off
    logic               zero_speed;         // below zero-speed threshold
    logic               safe_torque_off;    // external torque-off select
    logic               ramp_stop_command;  // high = on, rise = enable
  } drive_in_t;

  // software settings
  typedef struct packed {
    logic [1:0]  function_specification;
    logic        hysteresis_filter_enable;
    logic        pulse_suppression_behaviour_bit;
    logic [15:0] speed_limit;
    logic [15:0] speed_hysteresis;
    logic [15:0] feedback_filter_time;
  } config_t;

endpackage

// ===== feedback_filter.sv
// debounce style low-pass on the below-limit comparison
// assumes one clock and inputs synchronous to it
`timescale 1ns/10ps
`default_nettype none

module feedback_filter
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        enable,       // filter active
  input  wire logic [15:0] filter_time,  // cycles a change must persist
  // data
  input  wire logic        raw,
  output      logic        filtered
);

  logic [15:0] count;  // cycles the new value has persisted

  // ****************************************************************
  // filter: a change passes only after it held for filter_time cycles
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count    <= 16'h0000;
      filtered <= 1'b0;
    end
    else if (!enable || raw == filtered)
    begin
      // bypass or no pending change
      count    <= 16'h0000;
      filtered <= raw;
    end
    else if (count >= filter_time)
    begin
      count    <= 16'h0000;
      filtered <= raw;
    end
    else
    begin
      count <= count + 16'h0001;
    end
  end

endmodule // feedback_filter

`default_nettype wire

// ===== window_timer.sv
// one-shot restart window timer
// assumes start is a single-cycle strobe from the monitor; clear may stay high for many cycles
`timescale 1ns/10ps
`default_nettype none

module window_timer
#(
  parameter logic [31:0] WINDOW_CYCLES = 32'h1DCD6500
)
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic start,    // open the window
  input  wire logic clear,    // stop without expiry
  // status
  output      logic running,
  output      logic expired   // one-cycle pulse at window end
);

  logic [31:0] count;  // cycles elapsed in the window

  // ****************************************************************
  // counter; clear beats start, so an enable stops it except in the deselect cycle, where the monitor masks clear with win_start
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count   <= 32'h00000000;
      running <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (clear)
      begin
        running <= 1'b0;
        count   <= 32'h00000000;
      end
      else if (start)
      begin
        running <= 1'b1;
        count   <= 32'h00000000;
      end
      else if (running)
      begin
        if (count == WINDOW_CYCLES - 32'h00000001)
        begin
          running <= 1'b0;
          expired <= 1'b1;
        end
        else
        begin
          count <= count + 32'h00000001;
        end
      end
    end
  end

endmodule // window_timer

`default_nettype wire

// ===== safe_speed_monitor.sv
// encoderless safe speed monitor with apb registers
// assumes drive inputs synchronous to pclk; pclk runs at 100 mhz
//
// Functional notes
// - encoderless only when specification is 1 or 3
// - behaviour bit 1: feedback zero at suppression
// - behaviour bit 0: freeze feedback, internal torque off
// - torque off asserted when speed reaches zero
// - internal torque off blocks re-acceleration
// - deselect opens window; enable starts, expiry re-asserts
// - bit 1: monitoring ends, resumes on enable
// - bit 1: restart needs enable only
// - feedback stays high while speed below limit
// - feedback stays low without below-limit sample
// - feedback set when speed under limit
// - zero limit disables the monitor
// - one bit enables hysteresis and filter
//
// The address map and the APB slave port were left to the implementer.
`include "ssm_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module safe_speed_monitor
#(
  // restart window length in cycles, shortened in simulation
  parameter logic [31:0] WINDOW_CYCLES =
    32'(64'(`SSM_WINDOW_MS) * 64'd1000000 / 64'(`SSM_CLK_PERIOD_NS))
)
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  // drive side
  input  wire ssm_pkg::drive_in_t drive_in,
  output      logic              below_limit_feedback,
  output      logic              internal_safe_torque_off,
  output      logic              pulse_enable_permit
);
  import ssm_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  config_t        cfg;             // software settings
  monitor_state_t state;           // monitor sequence
  monitor_state_t next_state;
  logic           ramp_prev;       // last ramp stop level
  logic           enable_edge;     // rising edge = pulse enable
  logic           encoderless_ok;  // mode selected and limit set
  logic [15:0]    speed_mag;       // speed magnitude
  logic           raw_below;       // comparison before filter
  logic           filtered;        // comparison after filter
  logic           win_start;       // deselect edge strobe
  logic           win_clear;       // enable inside window, or any state but st_window
  logic           win_running;
  logic           win_expired;
  logic           apb_access;      // access phase of a transfer
  logic           apb_done;        // completing edge
  logic           addr_hit;        // decoded offset exists

  // ****************************************************************
  // helpers
  // ****************************************************************
  // magnitude of a signed speed, saturating the most negative value
  function automatic logic [15:0] magnitude(input logic signed [15:0] v);
    if (v == 16'sh8000)
      magnitude = 16'h7FFF;
    else if (v < 0)
      magnitude = 16'(-v);
    else
      magnitude = 16'(v);
  endfunction

  // true for a mapped register offset
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `SSM_CTRL_OFS) || (a == `SSM_LIMIT_OFS)
          || (a == `SSM_HYST_OFS) || (a == `SSM_FILTER_OFS)
          || (a == `SSM_STATUS_OFS);
  endfunction

  // ****************************************************************
  // apb slave: one wait state, then pready for a single cycle
  // ****************************************************************
  assign apb_access = psel && penable;
  assign apb_done   = apb_access && pready;
  assign addr_hit   = mapped(paddr);

  // ready and error strobes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apb_access && !pready;
      pslverr <= apb_access && !pready && !addr_hit;
    end
  end

  // register writes, taken only on the completing edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg.pulse_suppression_behaviour_bit <= `SSM_BEHAV_RST;
      cfg.hysteresis_filter_enable        <= `SSM_HYSTF_RST;
      cfg.function_specification          <= `SSM_FSPEC_RST;
      cfg.speed_limit                     <= `SSM_SPEED_RST;
      cfg.speed_hysteresis                <= `SSM_SPEED_RST;
      cfg.feedback_filter_time            <= `SSM_SPEED_RST;
    end
    else if (apb_done && pwrite)
    begin
      if (paddr == `SSM_CTRL_OFS)
      begin
        cfg.pulse_suppression_behaviour_bit <= pwdata[`SSM_CTRL_BEHAV_BIT];
        cfg.hysteresis_filter_enable        <= pwdata[`SSM_CTRL_HYSTF_BIT];
        cfg.function_specification <= pwdata[`SSM_CTRL_FSPEC_MSB:`SSM_CTRL_FSPEC_LSB];
      end
      else if (paddr == `SSM_LIMIT_OFS)
        cfg.speed_limit <= pwdata[15:0];
      else if (paddr == `SSM_HYST_OFS)
        cfg.speed_hysteresis <= pwdata[15:0];
      else if (paddr == `SSM_FILTER_OFS)
        cfg.feedback_filter_time <= pwdata[15:0];
      // status and unmapped offsets ignore writes
    end
  end

  // read data, loaded with the wait state so it is valid with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (apb_access && !pready && !pwrite)
    begin
      prdata <= 32'h00000000;
      if (paddr == `SSM_CTRL_OFS)
      begin
        prdata[`SSM_CTRL_BEHAV_BIT] <= cfg.pulse_suppression_behaviour_bit;
        prdata[`SSM_CTRL_HYSTF_BIT] <= cfg.hysteresis_filter_enable;
        prdata[`SSM_CTRL_FSPEC_MSB:`SSM_CTRL_FSPEC_LSB] <= cfg.function_specification;
      end
      else if (paddr == `SSM_LIMIT_OFS)
        prdata[15:0] <= cfg.speed_limit;
      else if (paddr == `SSM_HYST_OFS)
        prdata[15:0] <= cfg.speed_hysteresis;
      else if (paddr == `SSM_FILTER_OFS)
        prdata[15:0] <= cfg.feedback_filter_time;
      else if (paddr == `SSM_STATUS_OFS)
        prdata[3:0] <= {state != st_idle, win_running,
                        internal_safe_torque_off, below_limit_feedback};
    end
  end

  // ****************************************************************
  // speed comparison
  // ****************************************************************
  // only modes 1 and 3 run without encoder; zero limit switches off
  assign encoderless_ok =
    ((cfg.function_specification == `SSM_FSPEC_MODE_A) ||
     (cfg.function_specification == `SSM_FSPEC_MODE_B)) &&
    (cfg.speed_limit != 16'h0000);

  assign speed_mag = magnitude(drive_in.speed_actual);

  // with hysteresis the signal releases only at or above limit plus band
  always_comb
  begin
    if (cfg.hysteresis_filter_enable && filtered)
      raw_below = {1'b0, speed_mag} <
                  ({1'b0, cfg.speed_limit} + {1'b0, cfg.speed_hysteresis});
    else
      raw_below = speed_mag < cfg.speed_limit;
  end

  feedback_filter u_filter
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .enable      (cfg.hysteresis_filter_enable),
    .filter_time (cfg.feedback_filter_time),
    .raw         (raw_below),
    .filtered    (filtered)
  );

  // ****************************************************************
  // restart window
  // ****************************************************************
  // edge taken from the previous sample; inputs are already synchronous
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ramp_prev <= 1'b0;
    else
      ramp_prev <= drive_in.ramp_stop_command;
  end

  assign enable_edge = drive_in.ramp_stop_command && !ramp_prev;
  assign win_start   = (state == st_sto_sel) && !drive_in.safe_torque_off;
  assign win_clear   = (state != st_window) || enable_edge;

  window_timer #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_window
  (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (win_start),
    .clear   (win_clear && !win_start),
    .running (win_running),
    .expired (win_expired)
  );

  // ****************************************************************
  // monitor sequence
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    if (!encoderless_ok)
      next_state = st_idle;
    else
    begin
      case (state)
        st_idle:
          // power-up with pulses off goes through torque off only with behaviour bit 0
          if (!drive_in.pulses_suppressed)
            next_state = st_monitor;
          else if (cfg.pulse_suppression_behaviour_bit)
            next_state = st_supp_zero;
          else
            next_state = st_sto_hold;
        st_monitor:
          if (drive_in.pulses_suppressed)
            next_state = cfg.pulse_suppression_behaviour_bit ?
                         st_supp_zero : st_decay;
        st_supp_zero:
          if (enable_edge)
            next_state = st_monitor;
        st_decay:
          if (drive_in.zero_speed)
            next_state = st_sto_hold;
        st_sto_hold:
          if (drive_in.safe_torque_off)
            next_state = st_sto_sel;
        st_sto_sel:
          if (!drive_in.safe_torque_off)
            next_state = st_window;
        st_window:
          if (drive_in.safe_torque_off)
            next_state = st_sto_sel;
          else if (enable_edge)
            next_state = st_monitor;
          else if (win_expired)
            next_state = st_sto_hold;
        default:
          next_state = st_idle;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= st_idle;
    else
      state <= next_state;
  end

  // torque off and pulse permission follow the next state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      internal_safe_torque_off <= 1'b0;
      pulse_enable_permit      <= 1'b0;
    end
    else
    begin
      internal_safe_torque_off <= (next_state == st_sto_hold) ||
                                  (next_state == st_sto_sel)  ||
                                  (next_state == st_window);
      pulse_enable_permit <= (next_state == st_monitor) ||
                             (next_state == st_idle);
    end
  end

  // feedback: live, forced low or frozen depending on the sequence
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      below_limit_feedback <= 1'b0;
    else
    begin
      case (state)
        st_monitor:
          if (!drive_in.pulses_suppressed)
            below_limit_feedback <= filtered;
          else if (cfg.pulse_suppression_behaviour_bit)
            below_limit_feedback <= 1'b0;
        st_supp_zero, st_idle:
          below_limit_feedback <= 1'b0;
        default:
          // no speed can be estimated, so the last value is held
          below_limit_feedback <= below_limit_feedback;
      endcase
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  mode_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !encoderless_ok |=> state == st_idle && !internal_safe_torque_off)
    else $error("monitor active outside encoderless mode");

  limit_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.speed_limit == 16'h0000 |=> ##1 !below_limit_feedback)
    else $error("feedback high with zero limit");

  force_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_monitor && drive_in.pulses_suppressed
    && cfg.pulse_suppression_behaviour_bit |=> !below_limit_feedback)
    else $error("feedback not cleared at suppression");

  freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_monitor && drive_in.pulses_suppressed && encoderless_ok
    && !cfg.pulse_suppression_behaviour_bit
    |=> $stable(below_limit_feedback) && state == st_decay)
    else $error("feedback not frozen at suppression");

  sto_at_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_decay && drive_in.zero_speed && encoderless_ok
    |=> internal_safe_torque_off && !pulse_enable_permit)
    else $error("torque off missing at zero speed");

  sto_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
    internal_safe_torque_off |-> !pulse_enable_permit)
    else $error("pulses permitted under torque off");

  window_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_sto_sel && !drive_in.safe_torque_off && encoderless_ok
    |=> win_running && state == st_window)
    else $error("window not opened on deselect");

  window_expiry_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_window && win_expired && encoderless_ok
    && !drive_in.safe_torque_off && !enable_edge
    |=> state == st_sto_hold && internal_safe_torque_off)
    else $error("torque off not reasserted after window");

  window_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_window && enable_edge && encoderless_ok
    && !drive_in.safe_torque_off
    |=> pulse_enable_permit ##1 !win_running)
    else $error("enable inside window did not start motor");

  restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_supp_zero && enable_edge && encoderless_ok
    |=> state == st_monitor && pulse_enable_permit)
    else $error("restart on enable refused");

  below_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == st_monitor && !cfg.hysteresis_filter_enable && raw_below
    ##1 state == st_monitor && !drive_in.pulses_suppressed
    |=> below_limit_feedback)
    else $error("feedback not set below limit");

endmodule // safe_speed_monitor

`default_nettype wire

// ===== ssm_drive_model.sv
// far-side model: drive and safety controller around the speed monitor
// assumes the bench calls one task at a time from a single process
`timescale 1ns/10ps
`default_nettype none

module ssm_drive_model
(
  // clock
  input  wire logic               pclk,
  // drive signals into the monitor
  output var  ssm_pkg::drive_in_t drive_in
);
  import ssm_pkg::*;

  // ****************************************************************
  // controller commands
  // ****************************************************************
  // at rest: standstill, pulses on, ramp stop command on
  initial drive_in = 20'h00001;

  // speed estimate, applied at the next clock edge
  task automatic set_speed(input logic signed [15:0] s);
    @(posedge pclk);
    drive_in.speed_actual <= s;
  endtask

  // ramp stop, then the drive suppresses pulses a cycle later
  task automatic stop();
    @(posedge pclk);
    drive_in.ramp_stop_command <= 1'b0;
    @(posedge pclk);
    drive_in.pulses_suppressed <= 1'b1;
  endtask

  // speed decays below the zero-speed threshold
  task automatic decay();
    @(posedge pclk);
    drive_in.speed_actual <= 16'sh0000;
    drive_in.zero_speed   <= 1'b1;
  endtask

  // torque off selected for two cycles, then deselected
  task automatic cycle_sto();
    @(posedge pclk);
    drive_in.safe_torque_off <= 1'b1;
    repeat (2) @(posedge pclk);
    drive_in.safe_torque_off <= 1'b0;
  endtask

  // enable as a fresh rising edge; run lets pulses come back with it
  task automatic enable(input logic run);
    @(posedge pclk);
    drive_in.ramp_stop_command <= 1'b0;
    @(posedge pclk);
    // pulses return with the edge: the monitor drops back to its
    // suppressed state if they are still off once it resumes
    drive_in.ramp_stop_command <= 1'b1;
    drive_in.pulses_suppressed <= !run;
    drive_in.zero_speed        <= !run;
    repeat (3) @(posedge pclk);
  endtask
endmodule // ssm_drive_model
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the encoderless safe speed monitor
// assumes ssm_drive_model as the far side and a short restart window
`include "ssm_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import ssm_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  drive_in_t   drive_in;
  logic        fb;
  logic        isto;
  logic        permit;
  int          err_count;
  int          n_compared;
  int          cycles;

  // short window keeps the expiry case cheap
  safe_speed_monitor #(.WINDOW_CYCLES(32'h14)) i_safe_speed_monitor
    (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
     .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
     .drive_in(drive_in), .below_limit_feedback(fb), .internal_safe_torque_off(isto),
     .pulse_enable_permit(permit));
  ssm_drive_model i_ssm_drive_model (.pclk(pclk), .drive_in(drive_in));

  // ****************************************************************
  // helpers
  // ****************************************************************
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  // settle past the two-edge feedback delay
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    apb(1'b0, `SSM_CTRL_OFS, 32'h0, q, e);
    chk("ctrl reset", 32'h00000001, q);
    apb(1'b0, 12'h020, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
  endtask

  task automatic t_enable();
    wr(`SSM_LIMIT_OFS, 32'h64);
    i_ssm_drive_model.set_speed(16'sh0032);
    ticks(5);
    chk("fb spec 0", 32'h0, {31'h0, fb});
    wr(`SSM_CTRL_OFS, 32'h31);
    ticks(5);
    chk("fb spec 3", 32'h1, {31'h0, fb});
    i_ssm_drive_model.set_speed(-16'sh00C8);
    ticks(5);
    chk("fb over", 32'h0, {31'h0, fb});
    i_ssm_drive_model.set_speed(-16'sh0032);
    ticks(5);
    chk("fb under", 32'h1, {31'h0, fb});
    wr(`SSM_HYST_OFS, 32'h28);
    wr(`SSM_CTRL_OFS, 32'h33);
    i_ssm_drive_model.set_speed(16'sh0078);
    ticks(5);
    chk("fb hyst band", 32'h1, {31'h0, fb});
    i_ssm_drive_model.set_speed(16'sh0096);
    ticks(5);
    chk("fb hyst out", 32'h0, {31'h0, fb});
    i_ssm_drive_model.set_speed(-16'sh0032);
    ticks(5);
    chk("fb hyst back", 32'h1, {31'h0, fb});
    wr(`SSM_LIMIT_OFS, 32'h0);
    ticks(5);
    chk("fb zero limit", 32'h0, {31'h0, fb});
  endtask

  task automatic t_beh1();
    wr(`SSM_LIMIT_OFS, 32'h64);
    wr(`SSM_CTRL_OFS, 32'h11);
    ticks(5);
    chk("fb before stop", 32'h1, {31'h0, fb});
    i_ssm_drive_model.stop();
    ticks(5);
    chk("fb zeroed", 32'h0, {31'h0, fb});
    chk("no torque off", 32'h0, {31'h0, isto});
    i_ssm_drive_model.enable(1'b1);
    ticks(5);
    chk("permit", 32'h1, {31'h0, permit});
    chk("fb resumed", 32'h1, {31'h0, fb});
  endtask

  task automatic t_beh0();
    logic [31:0] q;
    logic        e;
    wr(`SSM_CTRL_OFS, 32'h10);
    i_ssm_drive_model.stop();
    ticks(5);
    chk("fb frozen", 32'h1, {31'h0, fb});
    chk("torque off early", 32'h0, {31'h0, isto});
    i_ssm_drive_model.decay();
    ticks(3);
    chk("torque off", 32'h1, {31'h0, isto});
    i_ssm_drive_model.enable(1'b0);
    ticks(3);
    chk("enable blocked", 32'h0, {31'h0, permit});
    chk("fb held", 32'h1, {31'h0, fb});
    i_ssm_drive_model.cycle_sto();
    ticks(3);
    apb(1'b0, `SSM_STATUS_OFS, 32'h0, q, e);
    chk("status window", 32'hF, q);
    ticks(30);
    chk("window expired", 32'h1, {31'h0, isto});
    apb(1'b0, `SSM_STATUS_OFS, 32'h0, q, e);
    chk("status expired", 32'hB, q);
    i_ssm_drive_model.cycle_sto();
    i_ssm_drive_model.enable(1'b1);
    ticks(3);
    chk("restart permit", 32'h1, {31'h0, permit});
    chk("restart sto", 32'h0, {31'h0, isto});
  endtask

  // ****************************************************************
  // clock, reset, timeout and main sequence
  // ****************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = !pclk;
  end

  // ceiling well above the few hundred cycles the run needs
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      wrap_up();
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {err_count, n_compared, cycles} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_enable();
    t_beh1();
    t_beh0();
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
